/* File: hw/wcs_sequencer.v */
// weld cycle sequencer: squeeze, weld, hold and end-of-sequence handshake
// assumes pins from outside the pclk domain and an APB master on pclk
`timescale 1ns/1ps
`include "wcs_defines.vh"

module wcs_sequencer #(
  parameter TICK_CYCLES = `WCS_TICK_US * `WCS_CLK_MHZ
)(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [7:0] prog_sel_in,
  input wire start1_in,
  input wire start2_in,
  input wire with_current_in,
  input wire pressure_ok_in,
  input wire estop_n_in,
  input wire mon_pass_in,
  output reg ready_out,
  output reg stroke_valve_out,
  output reg weld_good_out,
  output reg weld_fail_out,
  output reg cycle_done_out,
  output reg with_current_out,
  output reg current_on_out,
  output reg gun_two_out,
  output reg [7:0] active_prog_out,
  output reg [9:0] sys_msg_out
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_SQZ = 3'h1;
  localparam [2:0] ST_SQZ_WAIT = 3'h2;
  localparam [2:0] ST_WELD = 3'h3;
  localparam [2:0] ST_HOLD = 3'h4;
  localparam [2:0] ST_HOLD_MSG = 3'h5;
  localparam [2:0] ST_EOS = 3'h6;
  localparam [31:0] TICK_LAST = TICK_CYCLES - 1;

  // true once cnt whole ticks have reached the limit
  function reached;
    input [15:0] cnt;
    input [15:0] lim;
    begin
      reached = (cnt >= lim);
    end
  endfunction

  // saturating increment for ms counters
  function [15:0] sat_inc;
    input [15:0] v;
    begin
      if (v == 16'hFFFF)
        sat_inc = v;
      else
        sat_inc = v + 16'h0001;
    end
  endfunction

  reg [5:0] pin_meta_reg;
  reg [5:0] pin_sync_reg;
  reg [7:0] prog_meta_reg;
  reg [7:0] prog_sync_reg;
  reg [7:0] prog_prev_reg;
  reg [15:0] tick_cnt_reg;
  reg tick_reg;
  reg [15:0] sel_cnt_reg;
  reg [15:0] ms_cnt_reg;
  reg [15:0] ms_cnt_next;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [2:0] ctrl_reg;
  reg [15:0] sqz_reg;
  reg [15:0] weld_reg;
  reg [15:0] hold_reg;
  reg [15:0] cycles_reg;
  reg ack_reg;
  reg valve_next;
  reg good_next;
  reg fail_next;
  reg done_next;
  reg gun_next;
  reg [9:0] msg_next;
  reg [7:0] prog_next;
  reg [31:0] rd_next;
  reg err_next;

  wire start1_s = pin_sync_reg[0];
  wire start2_s = pin_sync_reg[1];
  wire with_cur_s = pin_sync_reg[2];
  wire press_s = pin_sync_reg[3];
  wire estop_n_s = pin_sync_reg[4];
  wire mon_pass_s = pin_sync_reg[5];
  wire manual = ctrl_reg[`WCS_CTRL_MANUAL];
  wire mon_en = ctrl_reg[`WCS_CTRL_MON];
  wire level_mode = ctrl_reg[`WCS_CTRL_LEVEL];
  wire sel_ok = (sel_cnt_reg > `WCS_SEL_MS);
  wire start_any = manual ? (start1_s | start2_s) : start1_s;
  wire start_cur = gun_two_out ? start2_s : start1_s;
  wire wr_en = psel & penable & pready & pwrite;
  wire setup = psel & ~penable;

  // two-stage synchronisers for all pins
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta_reg <= 6'h00;
      pin_sync_reg <= 6'h00;
      prog_meta_reg <= 8'h00;
      prog_sync_reg <= 8'h00;
    end
    else
    begin
      pin_meta_reg <= {mon_pass_in, estop_n_in, pressure_ok_in,
                       with_current_in, start2_in, start1_in};
      pin_sync_reg <= pin_meta_reg;
      prog_meta_reg <= prog_sel_in;
      prog_sync_reg <= prog_meta_reg;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_cnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end
    else if (tick_cnt_reg == TICK_LAST[15:0])
    begin
      tick_cnt_reg <= 16'h0000;
      tick_reg <= 1'b1;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
      tick_reg <= 1'b0;
    end
  end

  // program must stand still for more than 2 ms
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prog_prev_reg <= 8'h00;
      sel_cnt_reg <= 16'h0000;
    end
    else
    begin
      prog_prev_reg <= prog_sync_reg;
      if (prog_sync_reg != prog_prev_reg)
        sel_cnt_reg <= 16'h0000;
      else if (tick_reg)
        sel_cnt_reg <= sat_inc(sel_cnt_reg);
    end
  end

  // cycle sequencing
  always @*
  begin
    state_next = state_reg;
    valve_next = stroke_valve_out;
    good_next = weld_good_out;
    fail_next = weld_fail_out;
    done_next = cycle_done_out;
    gun_next = gun_two_out;
    msg_next = sys_msg_out;
    prog_next = active_prog_out;
    case (state_reg)
      ST_IDLE:
        if (start_any && ready_out)
        begin
          state_next = ST_SQZ;
          valve_next = 1'b1;
          good_next = 1'b0;
          fail_next = 1'b0;
          // gun from the start that fired
          gun_next = manual & start2_s & ~start1_s;
          prog_next = prog_sync_reg;
        end
      ST_SQZ, ST_SQZ_WAIT:
        if (level_mode && !start_cur)
        begin
          state_next = ST_IDLE;
          valve_next = 1'b0;
          msg_next = `WCS_MSG_NONE;
        end
        else if (state_reg == ST_SQZ_WAIT || reached(ms_cnt_reg, sqz_reg))
        begin
          if (press_s)
          begin
            // weld phase, start no longer aborts
            state_next = ST_WELD;
            msg_next = `WCS_MSG_NONE;
          end
          else
          begin
            state_next = ST_SQZ_WAIT;
            msg_next = `WCS_MSG_PRESS;
          end
        end
      ST_WELD:
        if (reached(ms_cnt_reg, weld_reg))
          state_next = ST_HOLD;
      ST_HOLD:
        if (reached(ms_cnt_reg, hold_reg))
        begin
          if (mon_en && mon_pass_s)
          begin
            good_next = 1'b1;
            done_next = 1'b1;
            valve_next = 1'b0;
            state_next = ST_EOS;
          end
          else
          begin
            fail_next = 1'b1;
            msg_next = `WCS_MSG_NOK;
            state_next = ST_HOLD_MSG;
          end
        end
      ST_HOLD_MSG:
        // stroke stays on while the message stands
        if (ack_reg)
        begin
          msg_next = `WCS_MSG_NONE;
          done_next = 1'b1;
          valve_next = 1'b0;
          state_next = ST_EOS;
        end
      ST_EOS:
        // at least 100 ms, then until start is gone
        if (ms_cnt_reg > `WCS_EOS_MS && !start_cur)
        begin
          done_next = 1'b0;
          state_next = ST_IDLE;
        end
      default:
        state_next = ST_IDLE;
    endcase
    // emergency stop aborts and hides results
    if (!estop_n_s)
    begin
      state_next = ST_IDLE;
      valve_next = 1'b0;
      good_next = 1'b0;
      fail_next = 1'b0;
      done_next = 1'b0;
      msg_next = `WCS_MSG_NONE;
    end
    if (state_next != state_reg)
      ms_cnt_next = 16'h0000;
    else if (tick_reg)
      ms_cnt_next = sat_inc(ms_cnt_reg);
    else
      ms_cnt_next = ms_cnt_reg;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= ST_IDLE;
      ms_cnt_reg <= 16'h0000;
      stroke_valve_out <= 1'b0;
      weld_good_out <= 1'b0;
      weld_fail_out <= 1'b0;
      cycle_done_out <= 1'b0;
      gun_two_out <= 1'b0;
      sys_msg_out <= `WCS_MSG_NONE;
      active_prog_out <= 8'h00;
      ready_out <= 1'b0;
      current_on_out <= 1'b0;
      with_current_out <= 1'b0;
      cycles_reg <= 16'h0000;
    end
    else
    begin
      state_reg <= state_next;
      ms_cnt_reg <= ms_cnt_next;
      stroke_valve_out <= valve_next;
      weld_good_out <= good_next;
      weld_fail_out <= fail_next;
      cycle_done_out <= done_next;
      gun_two_out <= gun_next;
      sys_msg_out <= msg_next;
      active_prog_out <= prog_next;
      // ready only when idle, clear and selection settled
      ready_out <= (state_next == ST_IDLE) && estop_n_s && sel_ok &&
                   (msg_next == `WCS_MSG_NONE);
      // current only in weld, with current and no stop
      current_on_out <= (state_next == ST_WELD) && with_cur_s && estop_n_s;
      with_current_out <= with_cur_s;
      if (state_next == ST_EOS && state_reg != ST_EOS)
        cycles_reg <= cycles_reg + 16'h0001;
    end
  end

  // apb register writes
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= `WCS_CTRL_RST;
      sqz_reg <= `WCS_SQZ_RST;
      weld_reg <= `WCS_WELD_RST;
      hold_reg <= `WCS_HOLD_RST;
      ack_reg <= 1'b0;
    end
    else
    begin
      ack_reg <= 1'b0;
      if (wr_en)
      begin
        if (paddr == `WCS_OFS_CTRL)
          ctrl_reg <= pwdata[2:0];
        else if (paddr == `WCS_OFS_SQZ)
          sqz_reg <= pwdata[15:0];
        else if (paddr == `WCS_OFS_WELD)
          weld_reg <= pwdata[15:0];
        else if (paddr == `WCS_OFS_HOLD)
          hold_reg <= pwdata[15:0];
        else if (paddr == `WCS_OFS_ACK)
          ack_reg <= pwdata[0];
      end
    end
  end

  // apb read data and error, prepared in the setup phase
  always @*
  begin
    rd_next = 32'h00000000;
    err_next = 1'b0;
    if (paddr == `WCS_OFS_CTRL)
      rd_next = {29'h00000000, ctrl_reg};
    else if (paddr == `WCS_OFS_SQZ)
      rd_next = {16'h0000, sqz_reg};
    else if (paddr == `WCS_OFS_WELD)
      rd_next = {16'h0000, weld_reg};
    else if (paddr == `WCS_OFS_HOLD)
      rd_next = {16'h0000, hold_reg};
    else if (paddr == `WCS_OFS_ACK)
      rd_next = 32'h00000000;
    else if (paddr == `WCS_OFS_STAT)
      rd_next = {6'h00, sys_msg_out, 5'h00, sel_ok, estop_n_s, ready_out,
                 cycle_done_out, weld_fail_out, weld_good_out,
                 stroke_valve_out, gun_two_out, state_reg};
    else if (paddr == `WCS_OFS_CYC)
      rd_next = {16'h0000, cycles_reg};
    else
      err_next = 1'b1;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setup;
      if (setup)
      begin
        prdata <= pwrite ? 32'h00000000 : rd_next;
        pslverr <= err_next;
      end
      else
      begin
        prdata <= 32'h00000000;
        pslverr <= 1'b0;
      end
    end
  end

endmodule

/* File: hw/wcs_defines.vh */
// constants of the weld cycle sequencer: offsets, fields, resets, timing
// assumes a single 50 MHz clock and a 32-bit APB register bus
`ifndef WCS_DEFINES_VH
`define WCS_DEFINES_VH

// timebase
`define WCS_CLK_MHZ 50
`define WCS_TICK_US 1000
`define WCS_SEL_MS 16'h0002
`define WCS_EOS_MS 16'h0064

// register byte offsets
`define WCS_OFS_CTRL 8'h00
`define WCS_OFS_SQZ 8'h04
`define WCS_OFS_WELD 8'h08
`define WCS_OFS_HOLD 8'h0C
`define WCS_OFS_ACK 8'h10
`define WCS_OFS_STAT 8'h14
`define WCS_OFS_CYC 8'h18

// control fields
`define WCS_CTRL_MANUAL 0
`define WCS_CTRL_MON 1
`define WCS_CTRL_LEVEL 2
`define WCS_CTRL_RST 3'h0

// phase time resets in ms
`define WCS_SQZ_RST 16'h000A
`define WCS_WELD_RST 16'h0005
`define WCS_HOLD_RST 16'h000A

// message codes
`define WCS_MSG_NONE 10'h000
`define WCS_MSG_PRESS 10'h166
`define WCS_MSG_NOK 10'h100

`endif

/* File: verif/wcs_chk.sv */
// checker of the weld cycle sequencer pin timing
// assumes binding to wcs_sequencer, one pclk domain
`timescale 1ns/1ps
module wcs_chk #(
  parameter TICK_CYCLES = 50000
)(
  input wire pclk,
  input wire presetn,
  input wire estop_n_in,
  input wire start1_in,
  input wire with_current_in,
  input wire ready_out,
  input wire stroke_valve_out,
  input wire weld_good_out,
  input wire weld_fail_out,
  input wire cycle_done_out,
  input wire with_current_out,
  input wire current_on_out,
  input wire [9:0] sys_msg_out
);
  localparam int EOS_MIN = 100 * TICK_CYCLES;
  int done_cnt;
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      done_cnt <= 0;
    else
      done_cnt <= cycle_done_out ? done_cnt + 1 : 0;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_stop_cut;
    !estop_n_in [*4] |-> !stroke_valve_out && !current_on_out && !cycle_done_out && !weld_good_out && !weld_fail_out;
  endproperty
  a_stop_cut: assert property (p_stop_cut) else $error("stop left outputs on");
  property p_stop_ready;
    !estop_n_in [*4] |-> !ready_out;
  endproperty
  a_stop_ready: assert property (p_stop_ready) else $error("ready under stop");
  property p_press_wait;
    sys_msg_out == 10'h166 |-> stroke_valve_out && !current_on_out;
  endproperty
  a_press_wait: assert property (p_press_wait) else $error("current while waiting");
  property p_eos_min;
    $fell(cycle_done_out) && estop_n_in |-> done_cnt >= EOS_MIN;
  endproperty
  a_eos_min: assert property (p_eos_min) else $error("end pulse too short");
  property p_eos_hold;
    (start1_in && estop_n_in) [*3] ##0 cycle_done_out |=> cycle_done_out;
  endproperty
  a_eos_hold: assert property (p_eos_hold) else $error("end dropped with start on");
  property p_valve_off;
    $rose(cycle_done_out) |-> !stroke_valve_out;
  endproperty
  a_valve_off: assert property (p_valve_off) else $error("valve on at end");
  property p_clear;
    $rose(stroke_valve_out) |=> !weld_good_out && !weld_fail_out;
  endproperty
  a_clear: assert property (p_clear) else $error("results kept at launch");
  property p_no_cur;
    !with_current_in [*4] |-> !current_on_out && !with_current_out;
  endproperty
  a_no_cur: assert property (p_no_cur) else $error("current without enable");
  property p_fail_hold;
    weld_fail_out && sys_msg_out == 10'h100 |-> !cycle_done_out && stroke_valve_out;
  endproperty
  a_fail_hold: assert property (p_fail_hold) else $error("end before acknowledge");
endmodule
bind wcs_sequencer wcs_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_i (.pclk, .presetn, .estop_n_in, .start1_in,
  .with_current_in, .ready_out, .stroke_valve_out, .weld_good_out, .weld_fail_out, .cycle_done_out,
  .with_current_out, .current_on_out, .sys_msg_out);

/* File: verif/wcs_ctl.sv */
// controller model: program selection, start and pressure contact
// assumes pclk of the sequencer and T cycles per millisecond
`timescale 1ns/1ps
module wcs_ctl #(
  parameter int T = 20
)(
  input wire pclk,
  input wire go,
  input wire gun2,
  input wire quick,
  input wire [7:0] prog,
  input wire estop_n_in,
  input wire stroke_valve_out,
  input wire cycle_done_out,
  output logic [7:0] prog_sel_in,
  output logic start1_in,
  output logic start2_in,
  output logic pressure_ok_in
);
  int i;
  initial
  begin
    prog_sel_in = 8'h00;
    start1_in = 0;
    start2_in = 0;
    pressure_ok_in = 0;
    forever
    begin
      @(posedge pclk);
      if (go)
      begin
        prog_sel_in <= prog;
        repeat (3 * T) @(posedge pclk);
        start1_in <= !gun2;
        start2_in <= gun2;
        for (i = 0; i < 200 * T && !stroke_valve_out; i++) @(posedge pclk);
        if (quick)
        begin
          // short start pulse, contact made at once
          pressure_ok_in <= 1;
          repeat (2 * T) @(posedge pclk);
        end
        else
        begin
          repeat (20 * T) @(posedge pclk);
          pressure_ok_in <= 1;
          for (i = 0; i < 400 * T && !cycle_done_out && estop_n_in; i++) @(posedge pclk);
          repeat (110 * T) @(posedge pclk);
          pressure_ok_in <= 0;
        end
        start1_in <= 0;
        start2_in <= 0;
      end
    end
  end
endmodule

/* File: verif/weld_cycle_sequencer_test.sv */
// bench of the weld cycle sequencer over APB and its pins
// assumes wcs_ctl drives the start handshake and wcs_chk is bound
`timescale 1ns/1ps
`include "wcs_defines.vh"
module weld_cycle_sequencer_test;
  localparam int T = 20;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00, prog = 8'h5A;
  logic [31:0] pwdata = 32'h0, rd;
  logic with_current_in = 1, estop_n_in = 1, mon_pass_in = 1, go = 0, gun2 = 0, quick = 0, last_err;
  int err_total = 0, n_checks = 0;
  wire [31:0] prdata;
  wire [7:0] prog_sel_in, active_prog_out;
  wire [9:0] sys_msg_out;
  wire pready, pslverr, start1_in, start2_in, pressure_ok_in, ready_out, stroke_valve_out;
  wire weld_good_out, weld_fail_out, cycle_done_out, with_current_out, current_on_out, gun_two_out;
  always #10 pclk = ~pclk;
  wcs_sequencer #(.TICK_CYCLES(T)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .prog_sel_in, .start1_in, .start2_in, .with_current_in, .pressure_ok_in,
    .estop_n_in, .mon_pass_in, .ready_out, .stroke_valve_out, .weld_good_out, .weld_fail_out,
    .cycle_done_out, .with_current_out, .current_on_out, .gun_two_out, .active_prog_out, .sys_msg_out);
  wcs_ctl #(.T(T)) ctl (.pclk, .go, .gun2, .quick, .prog, .estop_n_in, .stroke_valve_out, .cycle_done_out,
    .prog_sel_in, .start1_in, .start2_in, .pressure_ok_in);
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task bad;
    err_total++;
    $display("unexpected at %0t: wait ran out", $time);
    tally_and_finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge pclk);
    rd = prdata;
    last_err = pslverr;
    psel <= 0;
    penable <= 0;
    if (i == 20)
      bad;
  endtask
  function logic sg(input int s);
    return (s == 2) ? current_on_out : (s ? stroke_valve_out : cycle_done_out);
  endfunction
  task wt(input int s, input logic v);
    int i;
    for (i = 0; i < 20000 && sg(s) !== v; i++) @(posedge pclk);
    if (i == 20000)
      bad;
  endtask
  task cyc(input logic g);
    @(posedge pclk);
    gun2 <= g;
    go <= 1;
    @(posedge pclk);
    go <= 0;
    wt(1, 1);
    repeat (2) @(posedge pclk);
  endtask
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    repeat (5 * T) @(posedge pclk);
    apb(0, `WCS_OFS_SQZ, 0);
    chk(rd, `WCS_SQZ_RST);
    apb(0, `WCS_OFS_HOLD, 0);
    chk(rd, `WCS_HOLD_RST);
    apb(0, 8'h40, 0);
    chk(last_err, 1);
    chk(ready_out, 1);
    apb(1, `WCS_OFS_CTRL, 32'h2);
    apb(0, `WCS_OFS_CTRL, 0);
    chk(rd, 2);
    cyc(0);
    chk(ready_out, 0);
    chk(active_prog_out, 8'h5A);
    repeat (15 * T) @(posedge pclk);
    chk(sys_msg_out, `WCS_MSG_PRESS);
    wt(2, 1);
    chk(with_current_out, 1);
    wt(0, 1);
    chk({weld_good_out, weld_fail_out, stroke_valve_out}, 3'h4);
    wt(0, 0);
    apb(0, `WCS_OFS_CYC, 0);
    chk(rd, 1);
    $display("test good weld done");
    apb(1, `WCS_OFS_CTRL, 32'h0);
    with_current_in <= 0;
    mon_pass_in <= 0;
    cyc(0);
    chk(weld_good_out, 0);
    repeat (45 * T) @(posedge pclk);
    chk({weld_fail_out, cycle_done_out, stroke_valve_out, with_current_out}, 4'hA);
    chk(sys_msg_out, `WCS_MSG_NOK);
    apb(0, `WCS_OFS_STAT, 0);
    chk(rd, 32'h01000655);
    apb(1, `WCS_OFS_ACK, 32'h1);
    wt(0, 1);
    chk(sys_msg_out, `WCS_MSG_NONE);
    wt(0, 0);
    $display("test failed weld done");
    apb(1, `WCS_OFS_CTRL, 32'h3);
    with_current_in <= 1;
    mon_pass_in <= 1;
    cyc(1);
    chk(gun_two_out, 1);
    wt(0, 1);
    chk(weld_good_out, 1);
    wt(0, 0);
    $display("test gun two done");
    apb(1, `WCS_OFS_CTRL, 32'h2);
    quick <= 1;
    cyc(0);
    wt(0, 1);
    repeat (100 * T) @(posedge pclk);
    chk(cycle_done_out, 1);
    repeat (2 * T) @(posedge pclk);
    chk(cycle_done_out, 0);
    $display("test end pulse done");
    apb(1, `WCS_OFS_CTRL, 32'h6);
    cyc(0);
    wt(1, 0);
    chk({ready_out, cycle_done_out, sys_msg_out}, {1'b1, 1'b0, `WCS_MSG_NONE});
    apb(0, `WCS_OFS_CYC, 0);
    chk(rd, 4);
    $display("test level abort done");
    quick <= 0;
    apb(1, `WCS_OFS_CTRL, 32'h2);
    cyc(0);
    wt(2, 1);
    estop_n_in <= 0;
    repeat (5) @(posedge pclk);
    chk({stroke_valve_out, current_on_out, ready_out, cycle_done_out}, 4'h0);
    repeat (130 * T) @(posedge pclk);
    estop_n_in <= 1;
    repeat (5 * T) @(posedge pclk);
    chk(ready_out, 1);
    $display("test stop done");
    tally_and_finish;
  end
endmodule
